/* src/sbg_pkg.sv */
// sbg_pkg: register map, field positions, reset values and encodings
// for the sample buffer gate, flush and trigger control block.
// assumes 8-bit registers reached over a plain strobe port.
package sbg_pkg;

   // ****************************************************************
   // register offsets
   // ****************************************************************
   localparam logic [7:0] OFS_BUF_STATUS   = 8'h0B;
   localparam logic [7:0] OFS_SYSTEM_STATE = 8'h14;
   localparam logic [7:0] OFS_CONTROL      = 8'h15;
   localparam logic [7:0] OFS_SETUP_A      = 8'h26;
   localparam logic [7:0] OFS_SETUP_B      = 8'h27;
   localparam logic [7:0] OFS_SLEEP_PERIOD = 8'h29;

   // ****************************************************************
   // field positions
   // ****************************************************************
   // buffer_setup_a
   localparam int A_LIFO_POS    = 7;
   localparam int A_MODE_POS    = 5;
   localparam int A_GATE_POS    = 4;
   localparam int A_TRIG_WT_POS = 3;
   localparam int A_TRIG_OT_POS = 2;
   localparam int A_TRIG_OR_POS = 0;
   // buffer_setup_b
   localparam int B_FLUSH_POS   = 7;
   localparam int B_WAKE_SRC_POS = 6;
   localparam int B_WMRK_POS    = 0;
   // control
   localparam int C_ACTIVE_POS  = 0;
   localparam int C_EXT_POS     = 1;
   // buffer status
   localparam int S_WMRK_POS    = 7;
   localparam int S_OVF_POS     = 6;
   localparam int S_CNT_POS     = 0;
   // system_state_register
   localparam int Y_ERR_POS     = 7;
   localparam int Y_CNT_POS     = 2;
   localparam int Y_STATE_POS   = 0;

   // ****************************************************************
   // reset values and sizes
   // ****************************************************************
   localparam logic [7:0] RST_SETUP_A      = 8'h00;
   localparam logic [7:0] RST_SETUP_B      = 8'h00;
   localparam logic [7:0] RST_CONTROL      = 8'h00;
   localparam logic [7:0] RST_SLEEP_PERIOD = 8'h00;
   localparam logic [5:0] BUF_DEPTH        = 6'h20;
   localparam int         DROP_CNT_W       = 5;

   // ****************************************************************
   // encodings
   // ****************************************************************
   typedef enum logic [1:0] {
      MODE_OFF    = 2'h0,
      MODE_STREAM = 2'h1,
      MODE_STOP   = 2'h2,
      MODE_TRIG   = 2'h3
   } sbg_mode_e;

   typedef enum logic [1:0] {
      PS_STANDBY,
      PS_WAKE,
      PS_SLEEP,
      PS_EXT
   } sbg_power_e;

endpackage : sbg_pkg

/* src/sbg_sat_counter.sv */
// sbg_sat_counter: saturating event counter with synchronous clear.
// assumes inc and clr come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module sbg_sat_counter #(
   parameter int W = 5
) (
   // clock and reset
   input  wire logic         sys_clk,
   input  wire logic         rstn,
   // control
   input  wire logic         inc,
   input  wire logic         clr,
   // count
   output logic [W-1:0]      count
);

   logic [W-1:0] next_count;
   wire          at_max = &count;

   // an event in the clearing cycle is kept as the first count
   assign next_count = clr ? (inc ? {{(W-1){1'b0}}, 1'b1} : '0)
                     : ((inc && !at_max) ? count + 1'b1 : count);

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) count <= '0;
      else       count <= next_count;
   end

endmodule : sbg_sat_counter
`default_nettype wire

/* src/sbg_sleep_timer.sv */
// sbg_sleep_timer: counts sample periods spent awake; expires after
// the programmed period. assumes tick is one pulse per sample.
`timescale 1ns/100ps
`default_nettype none
module sbg_sleep_timer #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         sys_clk,
   input  wire logic         rstn,
   // control
   input  wire logic         restart,
   input  wire logic         tick,
   input  wire logic [W-1:0] period,
   // result
   output logic              expire
);

   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;

   assign expire   = tick && !restart && (period != '0) && (cnt >= period - 1'b1);
   assign next_cnt = (restart || expire) ? '0 : (tick ? cnt + 1'b1 : cnt);

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) cnt <= '0;
      else       cnt <= next_cnt;
   end

endmodule : sbg_sleep_timer
`default_nettype wire

/* src/sbg_buffer_ctrl.sv */
// sbg_buffer_ctrl: control of the 32-sample output buffer: input gate,
// gated drop flag and count, flush sources, trigger capture and the
// wake/sleep sequencing that triggered capture depends on.
// assumes sample path, event sources and host read strobe share sys_clk;
// storage and read-out ordering live outside and obey buf_store,
// buf_drop_oldest and buf_flush.
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - gate off: auto wake/sleep change flushes the whole buffer.
// - gate on: after wake/sleep change keep contents, store nothing until emptied/flushed.
// - samples at closed gate are discarded, raise drop flag, count drops.
// - drop flag holds while the buffer is not yet empty.
// - triggered mode with sleep period at least one ignores the gate enable.
// - after flushing a gated buffer, storing resumes at the current state's rate.
// - three enable bits pick trigger sources; 0 off by default, 1 on.
// - flush on mode disabled, flush request, or wake/sleep change without gate.
// - flush when leaving standby for active or external trigger state.
// - disabling clears overflow flag, watermark flag and sample count.
// - drop flag and drop count reset on disable, flush or full read-out.
// - triggered with sleep period: activate wakes at once, sleeps after period, flushing.
// - before trigger, fill circularly at sleep rate up to watermark samples.
// - after trigger stay awake, ignore triggers, store 32-watermark, set overflow, stop.
// - empty or flush re-arms; next capture waits for sleep state first.
// - triggered with auto-sleep always flushes on wake-to-sleep.
// - anything preventing sleep also prevents triggered capture.
// - mode codes 00 off, 01 stream, 10 stop-when-full, 11 triggered.
// - flush request bit self-clears, never reads back as one.
// - watermark flag when count at least watermark; zero watermark disables it.
module sbg_buffer_ctrl
   import sbg_pkg::*;
#(
   parameter int SLEEP_W = 8
) (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   // register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // sample path
   input  wire logic       sample_tick,
   input  wire logic       sample_read,
   output logic            buf_store,
   output logic            buf_drop_oldest,
   output logic            buf_flush,
   output logic      [5:0] buf_count,
   output logic            buf_lifo,
   // event sources
   input  wire logic       ev_within,
   input  wire logic       ev_outside,
   input  wire logic       ev_orient,
   input  wire logic       wake_event,
   input  wire logic       wake_hold,
   // power state
   output logic            wake_state,
   output logic      [1:0] power_state
);

   // ****************************************************************
   // registers written by software
   // ****************************************************************
   logic [7:0]         setup_a;
   logic [6:0]         setup_b;
   logic [1:0]         control;
   logic [SLEEP_W-1:0] sleep_period;

   wire wr_a     = reg_wr && (reg_addr == OFS_SETUP_A);
   wire wr_b     = reg_wr && (reg_addr == OFS_SETUP_B);
   wire wr_ctrl  = reg_wr && (reg_addr == OFS_CONTROL);
   wire wr_sleep = reg_wr && (reg_addr == OFS_SLEEP_PERIOD);

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         setup_a      <= RST_SETUP_A;
         setup_b      <= RST_SETUP_B[6:0];
         control      <= RST_CONTROL[1:0];
         sleep_period <= SLEEP_W'(RST_SLEEP_PERIOD);
      end else begin
         if (wr_a)     setup_a      <= reg_wdata;
         if (wr_b)     setup_b      <= reg_wdata[6:0];
         if (wr_ctrl)  control      <= reg_wdata[1:0];
         if (wr_sleep) sleep_period <= SLEEP_W'(reg_wdata);
      end
   end

   // ****************************************************************
   // field decode
   // ****************************************************************
   sbg_mode_e  mode;
   sbg_power_e ps;
   sbg_power_e next_ps;

   assign mode = sbg_mode_e'(setup_a[A_MODE_POS +: 2]);
   wire       gate_en   = setup_a[A_GATE_POS];
   wire       en_wt     = setup_a[A_TRIG_WT_POS];
   wire       en_ot     = setup_a[A_TRIG_OT_POS];
   wire       en_or     = setup_a[A_TRIG_OR_POS];
   wire       wake_src  = setup_b[B_WAKE_SRC_POS];
   wire [5:0] wmrk      = setup_b[B_WMRK_POS +: 6];
   wire       active    = control[C_ACTIVE_POS];
   wire       ext_sel   = control[C_EXT_POS];
   wire       flush_req = wr_b && reg_wdata[B_FLUSH_POS];
   wire       aslp_on   = (sleep_period != '0);
   wire       trig_aslp = (mode == MODE_TRIG) && aslp_on;
   wire       gate_eff  = gate_en && !trig_aslp;
   wire [5:0] pre_lim   = (wmrk > BUF_DEPTH) ? BUF_DEPTH : wmrk;
   wire       any_trig  = (en_wt && ev_within) || (en_ot && ev_outside) || (en_or && ev_orient);

   // ****************************************************************
   // buffer state
   // ****************************************************************
   logic [5:0] count;
   logic       ovf;
   logic       gate_closed;
   logic       gate_err;
   logic       triggered;
   logic [5:0] post_cnt;
   logic [DROP_CNT_W-1:0] drop_cnt;

   wire full      = (count >= BUF_DEPTH);
   wire wmrk_flag = (wmrk != 6'h00) && (count >= wmrk);
   wire post_done = (post_cnt >= BUF_DEPTH - pre_lim);
   wire running   = (ps != PS_STANDBY);

   // ****************************************************************
   // power sequencing
   // ****************************************************************
   logic timer_exp;
   wire  trig_fire;

   // any hold on wake also holds off triggered capture via sleep
   wire hold_wake = wake_hold
                  || (trig_aslp && triggered)
                  || (wake_src && (wmrk_flag || ovf)
                      && (mode == MODE_STREAM || mode == MODE_STOP));

   sbg_sleep_timer #(
      .W       (SLEEP_W)
   ) u_sleep_timer (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .restart ((ps != PS_WAKE) || hold_wake),
      .tick    (sample_tick),
      .period  (sleep_period),
      .expire  (timer_exp)
   );

   always_comb begin
      next_ps = ps;
      unique case (ps)
         PS_STANDBY: begin
            if (active) next_ps = ext_sel ? PS_EXT : PS_WAKE;
         end
         PS_WAKE: begin
            if (!active)                              next_ps = PS_STANDBY;
            else if (aslp_on && timer_exp && !hold_wake) next_ps = PS_SLEEP;
         end
         PS_SLEEP: begin
            if (!active)                      next_ps = PS_STANDBY;
            else if (wake_event || trig_fire) next_ps = PS_WAKE;
         end
         PS_EXT: begin
            if (!active) next_ps = PS_STANDBY;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) ps <= PS_STANDBY;
      else       ps <= next_ps;
   end

   wire leave_standby = (ps == PS_STANDBY) && (next_ps != PS_STANDBY);
   wire to_sleep      = (ps == PS_WAKE) && (next_ps == PS_SLEEP);
   wire to_wake       = (ps == PS_SLEEP) && (next_ps == PS_WAKE);
   wire ws_change     = to_sleep || to_wake;

   // ****************************************************************
   // flush sources
   // ****************************************************************
   wire flush_now = (mode == MODE_OFF)
                  || flush_req
                  || leave_standby
                  || (ws_change && !gate_eff && !trig_aslp)
                  || (to_sleep && trig_aslp);

   // ****************************************************************
   // sample acceptance
   // ****************************************************************
   // capture fires only from sleep when auto-sleep is in use
   assign trig_fire = (mode == MODE_TRIG) && !triggered && !flush_now && any_trig
                    && (trig_aslp ? (ps == PS_SLEEP) : running);

   // gate closes only over a non-empty buffer
   wire accept = sample_tick && running && !flush_now && !gate_closed;
   wire drop   = sample_tick && running && !flush_now && gate_closed
               && (mode != MODE_OFF);

   always_comb begin
      buf_store       = 1'b0;
      buf_drop_oldest = 1'b0;
      unique case (mode)
         MODE_OFF: begin
            buf_store = 1'b0;
         end
         MODE_STREAM: begin
            buf_store       = accept;
            buf_drop_oldest = accept && full;
         end
         MODE_STOP: begin
            buf_store = accept && !full;
         end
         MODE_TRIG: begin
            if (!triggered) begin
               buf_store       = accept && (pre_lim != 6'h00);
               buf_drop_oldest = accept && (pre_lim != 6'h00) && (count >= pre_lim);
            end else begin
               buf_store = accept && !post_done;
            end
         end
      endcase
   end

   wire inc     = buf_store && !buf_drop_oldest;
   wire dec     = sample_read && (count != 6'h00);
   wire emptied = dec && (count == 6'h01) && !inc;
   wire post_last = triggered && buf_store && (post_cnt + 6'h01 >= BUF_DEPTH - pre_lim);

   wire ovf_set = (mode == MODE_STREAM && buf_drop_oldest)
                || (mode == MODE_STOP && accept && full)
                || (mode == MODE_TRIG && post_last);
   wire ovf_clr = flush_now || emptied
                || (dec && mode != MODE_TRIG);

   // ****************************************************************
   // state update
   // ****************************************************************
   logic [5:0] next_count;
   assign next_count = flush_now ? 6'h00 : (count + {5'h00, inc} - {5'h00, dec});

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         count <= 6'h00;
         ovf   <= 1'b0;
      end else begin
         count <= next_count;
         ovf   <= ovf_set || (ovf && !ovf_clr);
      end
   end

   // gate and capture control
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         gate_closed <= 1'b0;
         triggered   <= 1'b0;
         post_cnt    <= 6'h00;
      end else begin
         if (flush_now || emptied)                         gate_closed <= 1'b0;
         else if (ws_change && gate_eff && count != 6'h00) gate_closed <= 1'b1;
         if (trig_fire)                 triggered <= 1'b1;
         else if (flush_now || emptied) triggered <= 1'b0;
         if (trig_fire)                    post_cnt <= 6'h00;
         else if (triggered && buf_store)  post_cnt <= post_cnt + 6'h01;
      end
   end

   // ****************************************************************
   // gated drop flag and counter
   // ****************************************************************
   wire err_clr = flush_now || emptied;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) gate_err <= 1'b0;
      else       gate_err <= drop || (gate_err && !err_clr);
   end

   sbg_sat_counter #(
      .W       (DROP_CNT_W)
   ) u_drop_count (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .inc     (drop),
      .clr     (err_clr),
      .count   (drop_cnt)
   );

   // ****************************************************************
   // outputs and read-back
   // ****************************************************************
   assign buf_flush   = flush_now;
   assign buf_count   = count;
   assign buf_lifo    = setup_a[A_LIFO_POS];
   assign wake_state  = (ps == PS_WAKE) || (ps == PS_EXT);
   assign power_state = ps;

   wire [7:0] rd_status = {wmrk_flag, ovf, count};
   wire [7:0] rd_system = {gate_err, drop_cnt, ps};
   wire [7:0] rd_sleep  = 8'(sleep_period);

   wire [7:0] rd_mux = (reg_addr == OFS_SETUP_A)      ? setup_a
                     : (reg_addr == OFS_SETUP_B)      ? {1'b0, setup_b}
                     : (reg_addr == OFS_CONTROL)      ? {6'h00, control}
                     : (reg_addr == OFS_SLEEP_PERIOD) ? rd_sleep
                     : (reg_addr == OFS_BUF_STATUS)   ? rd_status
                     : (reg_addr == OFS_SYSTEM_STATE) ? rd_system
                     : 8'h00;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn)       reg_rdata <= 8'h00;
      else if (reg_rd) reg_rdata <= rd_mux;
      else             reg_rdata <= 8'h00;
   end

endmodule : sbg_buffer_ctrl
`default_nettype wire

/* testbench/sbg_buffer_ctrl_sva.sv */
// sbg_buffer_ctrl_sva: port-level checks of the buffer control block.
// assumes it is bound onto sbg_buffer_ctrl; config is shadowed from writes.
`timescale 1ns/100ps
`default_nettype none
module sbg_buffer_ctrl_sva
   import sbg_pkg::*;
(
   // clock and reset
   input wire logic       sys_clk,
   input wire logic       rstn,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   // sample path and state
   input wire logic       sample_read,
   input wire logic       buf_store,
   input wire logic       buf_drop_oldest,
   input wire logic       buf_flush,
   input wire logic [5:0] buf_count,
   input wire logic [1:0] power_state
);
   // ********
   // shadows
   // ********
   logic [1:0] mode_q;
   logic       gate_q;
   logic       per_nz;
   wire        trig_as = (mode_q == MODE_TRIG) && per_nz;
   wire        ws_move = (power_state == PS_SLEEP) || (power_state == PS_WAKE);

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         mode_q <= 2'h0;
         gate_q <= 1'h0;
         per_nz <= 1'h0;
      end else if (reg_wr && reg_addr == OFS_SETUP_A) begin
         mode_q <= reg_wdata[6:5];
         gate_q <= reg_wdata[A_GATE_POS];
      end else if (reg_wr && reg_addr == OFS_SLEEP_PERIOD) begin
         per_nz <= |reg_wdata;
      end
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   // ********
   // checks
   // ********
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside read answer");
   a_flush_reads_zero: assert property (
      reg_rd && reg_addr == OFS_SETUP_B |=> !reg_rdata[B_FLUSH_POS])
      else $error("flush request bit read back as one");
   a_off_flush: assert property (mode_q == MODE_OFF |-> buf_flush)
      else $error("disabled buffer not flushed");
   a_off_nostore: assert property (mode_q == MODE_OFF |-> !buf_store)
      else $error("store while disabled");
   a_flush_clears_count: assert property (buf_flush |=> buf_count == 6'h00)
      else $error("count not cleared after flush");
   a_standby_exit_flush: assert property (
      $past(power_state) == PS_STANDBY && power_state != PS_STANDBY |-> buf_flush || $past(buf_flush))
      else $error("no flush on leaving standby");
   a_gate_off_flush: assert property (
      !gate_q && !trig_as && ws_move && $past(power_state) != power_state
      && ($past(power_state) == PS_SLEEP || $past(power_state) == PS_WAKE)
      |-> buf_flush || $past(buf_flush))
      else $error("no flush on wake sleep change with gate off");
   a_trig_sleep_flush: assert property (
      trig_as && $past(power_state) == PS_WAKE && power_state == PS_SLEEP |-> buf_flush || $past(buf_flush))
      else $error("no flush on wake to sleep in triggered mode");
   a_drop_with_store: assert property (buf_drop_oldest |-> buf_store && !buf_flush)
      else $error("drop oldest without a store");
   a_count_step: assert property (
      buf_store && !buf_drop_oldest && !buf_flush && !sample_read |=> buf_count == $past(buf_count) + 6'h01)
      else $error("count did not step on store");
endmodule : sbg_buffer_ctrl_sva

bind sbg_buffer_ctrl sbg_buffer_ctrl_sva u_sva (
   .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_read(sample_read), .buf_store(buf_store),
   .buf_drop_oldest(buf_drop_oldest), .buf_flush(buf_flush), .buf_count(buf_count),
   .power_state(power_state)
);
`default_nettype wire

/* testbench/test_sample_buffer_gate_flush_trigger.sv */
// test_sample_buffer_gate_flush_trigger: directed bench of the buffer control.
// assumes the checker binds itself from its own file.
`timescale 1ns/100ps
`default_nettype none
module test_sample_buffer_gate_flush_trigger
   import sbg_pkg::*;
();
   logic       sys_clk, rstn, reg_wr, reg_rd, sample_tick, sample_read;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic       ev_within, ev_outside, ev_orient, wake_event, wake_hold;
   logic       buf_store, buf_drop_oldest, buf_flush, buf_lifo, wake_state;
   logic [5:0] buf_count;
   logic [1:0] power_state;
   int         err_total;
   int         n_tests;

   sbg_buffer_ctrl dut_u (
      .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_tick(sample_tick), .sample_read(sample_read),
      .buf_store(buf_store), .buf_drop_oldest(buf_drop_oldest), .buf_flush(buf_flush),
      .buf_count(buf_count), .buf_lifo(buf_lifo), .ev_within(ev_within), .ev_outside(ev_outside),
      .ev_orient(ev_orient), .wake_event(wake_event), .wake_hold(wake_hold),
      .wake_state(wake_state), .power_state(power_state));

   initial sys_clk = 1'h0;
   always #10 sys_clk = ~sys_clk;

   // ********
   // helpers
   // ********
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge sys_clk);
      reg_wr <= 1'h0;
      @(posedge sys_clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge sys_clk);
      reg_rd <= 1'h0;
      #1 chk(reg_rdata, exp);
      @(posedge sys_clk);
   endtask : rd
   task automatic tick(input int n);
      sample_tick <= 1'h1;
      repeat (n) @(posedge sys_clk);
      sample_tick <= 1'h0;
      @(posedge sys_clk);
   endtask : tick
   task automatic ev(input logic [2:0] v);
      {ev_within, ev_outside, ev_orient} <= v;
      @(posedge sys_clk);
      {ev_within, ev_outside, ev_orient} <= 3'h0;
      @(posedge sys_clk);
   endtask : ev
   task automatic wait_ps(input logic [1:0] ps);
      for (int i = 0; i < 64 && power_state !== ps; i++) @(posedge sys_clk);
      #1 chk({6'h00, power_state}, {6'h00, ps});
   endtask : wait_ps

   // ********
   // scenarios
   // ********
   task automatic t_reset;
      logic [7:0] offs [7] = '{OFS_SETUP_A, OFS_SETUP_B, OFS_BUF_STATUS, OFS_SYSTEM_STATE,
                               OFS_CONTROL, OFS_SLEEP_PERIOD, 8'h3F};
      foreach (offs[i]) rd(offs[i], 8'h00);
      chk({7'h00, buf_flush}, 8'h01);
      wr(OFS_SETUP_A, 8'hAD);
      rd(OFS_SETUP_A, 8'hAD);
      chk({7'h00, buf_lifo}, 8'h01);
      wr(OFS_SETUP_B, 8'h82);
      rd(OFS_SETUP_B, 8'h02);
      $display("test reset and registers done");
   endtask : t_reset
   task automatic t_stream;
      wake_hold <= 1'h1;
      wr(OFS_CONTROL, 8'h01);
      wait_ps(PS_WAKE);
      tick(3);
      rd(OFS_BUF_STATUS, 8'h83);
      wr(OFS_SETUP_B, 8'h00);
      rd(OFS_BUF_STATUS, 8'h03);
      wr(OFS_SETUP_B, 8'h80);
      rd(OFS_BUF_STATUS, 8'h00);
      tick(1);
      wr(OFS_SETUP_A, 8'h4D);
      tick(33);
      rd(OFS_BUF_STATUS, 8'h60);
      wr(OFS_SETUP_A, 8'h0D);
      rd(OFS_BUF_STATUS, 8'h00);
      chk({7'h00, buf_flush}, 8'h01);
      $display("test stream done");
   endtask : t_stream
   task automatic t_gate;
      int c;
      wake_hold <= 1'h0;
      wr(OFS_CONTROL, 8'h00);
      wr(OFS_SETUP_A, 8'h30);
      wr(OFS_SLEEP_PERIOD, 8'h02);
      wr(OFS_CONTROL, 8'h03);
      wait_ps(PS_EXT);
      chk({7'h00, wake_state}, 8'h01);
      wr(OFS_CONTROL, 8'h00);
      wr(OFS_CONTROL, 8'h01);
      tick(2);
      wait_ps(PS_SLEEP);
      c = int'(buf_count);
      tick(3);
      #1 chk({2'h0, buf_count}, c[7:0]);
      rd(OFS_SYSTEM_STATE, 8'h8E);
      tick(40);
      rd(OFS_SYSTEM_STATE, 8'hFE);
      sample_read <= 1'h1;
      repeat (c) @(posedge sys_clk);
      sample_read <= 1'h0;
      @(posedge sys_clk);
      rd(OFS_SYSTEM_STATE, 8'h02);
      tick(1);
      #1 chk({2'h0, buf_count}, 8'h01);
      wr(OFS_SETUP_A, 8'h20);
      wake_event <= 1'h1;
      @(posedge sys_clk);
      wake_event <= 1'h0;
      wait_ps(PS_WAKE);
      chk({2'h0, buf_count}, 8'h00);
      $display("test gate done");
   endtask : t_gate
   task automatic t_trig;
      wr(OFS_CONTROL, 8'h00);
      wr(OFS_SETUP_B, 8'h02);
      wr(OFS_SETUP_A, 8'h78);
      wr(OFS_CONTROL, 8'h01);
      #1 chk({6'h00, power_state}, {6'h00, PS_WAKE});
      tick(2);
      wait_ps(PS_SLEEP);
      chk({7'h00, wake_state}, 8'h00);
      chk({2'h0, buf_count}, 8'h00);
      tick(5);
      #1 chk({2'h0, buf_count}, 8'h02);
      sample_tick <= 1'h1;
      #1 chk({6'h00, buf_store, buf_drop_oldest}, 8'h03);
      @(posedge sys_clk);
      sample_tick <= 1'h0;
      ev(3'h3);
      wait_ps(PS_SLEEP);
      ev(3'h4);
      wait_ps(PS_WAKE);
      chk({7'h00, wake_state}, 8'h01);
      tick(33);
      ev(3'h4);
      rd(OFS_BUF_STATUS, 8'hE0);
      chk({6'h00, power_state}, {6'h00, PS_WAKE});
      wr(OFS_SETUP_B, 8'h82);
      rd(OFS_BUF_STATUS, 8'h00);
      tick(2);
      wait_ps(PS_SLEEP);
      $display("test trigger done");
   endtask : t_trig

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done

   initial begin
      {rstn, reg_wr, reg_rd, sample_tick, sample_read} = 5'h00;
      {reg_addr, reg_wdata} = 16'h0000;
      {ev_within, ev_outside, ev_orient, wake_event, wake_hold} = 5'h00;
      repeat (5) @(posedge sys_clk);
      rstn <= 1'h1;
      @(posedge sys_clk);
      t_reset;
      t_stream;
      t_gate;
      t_trig;
      test_done;
   end

   initial begin
      repeat (5000) @(posedge sys_clk);
      err_total++;
      test_done;
   end
endmodule : test_sample_buffer_gate_flush_trigger
`default_nettype wire
